// file: pkg/cld_cfg.svh
// constants for the character display instruction decoder
`ifndef CLD_CFG_SVH
`define CLD_CFG_SVH
`define CLD_SPACE_CODE      8'h20
`define CLD_ROW1_FIRST      7'h00
`define CLD_ROW1_LAST       7'h13
`define CLD_ROW2_FIRST      7'h40
`define CLD_ROW2_LAST       7'h53
`define CLD_BUF_DEPTH       40
`define CLD_GLYPH_DEPTH     64
`define CLD_CLK_HZ          50000000
`define CLD_OSC_HZ          270000
`define CLD_LONG_NS         1520000
`define CLD_SHORT_NS        38000
`define CLD_LONG_CYC        ((`CLD_LONG_NS * (`CLD_CLK_HZ / 1000000) + 999) / 1000)
`define CLD_SHORT_CYC       ((`CLD_SHORT_NS * (`CLD_CLK_HZ / 1000000) + 999) / 1000)
`endif

// file: pkg/cld_pkg.sv
// types for the character display instruction decoder
package cld_pkg;
    typedef enum logic [3:0] {
        CLD_OP_NONE, CLD_OP_CLEAR, CLD_OP_HOME, CLD_OP_ENTRY, CLD_OP_DISP,
        CLD_OP_SHIFT, CLD_OP_FUNC, CLD_OP_GLYPH_ADDR, CLD_OP_BUF_ADDR
    } cld_op_t;
    typedef enum logic [1:0] {CLD_ST_IDLE, CLD_ST_CLEAR, CLD_ST_WAIT} cld_state_t;
endpackage

// file: rtl/cld_busy_timer.sv
// busy timer holding the pending flag for an execution time
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_busy_timer (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        start_long,
    input  wire logic        start_short,
    output logic             pending
);
    parameter int LONG_CYC = `CLD_LONG_CYC;
    localparam int SHORT_CYC = `CLD_SHORT_CYC;
    logic [16:0] cnt_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 17'h00000;
        end else if (start_long) begin
            cnt_r <= 17'(LONG_CYC);
        end else if (start_short) begin
            cnt_r <= 17'(SHORT_CYC);
        end else if (cnt_r != 17'h00000) begin
            cnt_r <= cnt_r - 17'h00001;
        end
    end

    assign pending = (cnt_r != 17'h00000);
endmodule

// file: rtl/cld_decoder.sv
// instruction decoder, address pointer and display RAMs
//
// Behaviour
// - rows map to 00-13h and 40-53h
// - clear fills buffer with spaces, pointer zero
// - clear homes cursor, forces increment
// - home zeroes pointer, undoes shift
// - clear and home busy 1.52 ms
// - other operations busy 38 us, except status read and the empty 00h instruction
// - status read gives pending flag and pointer
// - bit 6 leader selects glyph RAM address
// - bit 7 leader selects buffer address
// - increment steps pointer up, cursor right
// - decrement steps pointer down, cursor left
// - glyph accesses step pointer likewise
// - auto scroll shifts display on buffer writes
// - no shift on reads or glyph access
// - bit 4 leader moves cursor or shifts
// - bit 5 leader latches width, rows, height
// - bit 3 leader latches panel, cursor, blink
// - data write stores into selected RAM
// - data read drives selected RAM out
// - select high data, low instruction
// - panel off blanks, keeps buffer
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_decoder (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        cmd_data_select,
    input  wire logic        dir_read,
    input  wire logic        strobe,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             internal_op_pending,
    output logic      [6:0]  addr_pointer,
    output logic             panel_on,
    output logic             cursor_on,
    output logic             blink_on,
    output logic             bus_width_sel,
    output logic             two_rows,
    output logic             tall_glyph,
    output logic             step_up,
    output logic             auto_scroll,
    output logic      [5:0]  scroll_offset
);
    import cld_pkg::*;
    parameter int LONG_CYC = `CLD_LONG_CYC;

    logic              rst_s1_r;
    logic              rst_s2_r;
    logic              strobe_d_r;
    logic              take;
    logic              pending;
    logic              start_long;
    logic              start_short;
    cld_op_t           op;
    cld_state_t        state_r;
    logic        [5:0] clr_idx_r;
    logic              glyph_sel_r;
    logic        [7:0] buf_mem  [`CLD_BUF_DEPTH];
    logic        [7:0] glyph_mem[`CLD_GLYPH_DEPTH];
    logic        [6:0] ptr_nxt;
    logic              scroll_step;
    logic              scroll_left;

    // maps a pointer onto buffer storage: row one 00-13h, row two 40-53h
    function automatic logic [5:0] buf_index(input logic [6:0] a);
        logic [5:0] lo;
        lo = (a[5:0] > 6'h13) ? 6'h13 : a[5:0];
        return a[6] ? lo + 6'h14 : lo;
    endfunction

    // leading one picks the instruction, lower bits don't care
    function automatic cld_op_t decode(input logic [7:0] d);
        if (d[7])      return CLD_OP_BUF_ADDR;
        else if (d[6]) return CLD_OP_GLYPH_ADDR;
        else if (d[5]) return CLD_OP_FUNC;
        else if (d[4]) return CLD_OP_SHIFT;
        else if (d[3]) return CLD_OP_DISP;
        else if (d[2]) return CLD_OP_ENTRY;
        else if (d[1]) return CLD_OP_HOME;
        else if (d[0]) return CLD_OP_CLEAR;
        else           return CLD_OP_NONE;
    endfunction

    function automatic logic [6:0] step(input logic [6:0] a, input logic up);
        return up ? a + 7'h01 : a - 7'h01;
    endfunction

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // rising strobe edge takes an access; instructions held off while busy
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            strobe_d_r <= 1'b0;
        end else begin
            strobe_d_r <= strobe;
        end
    end
    assign take = strobe & ~strobe_d_r & (state_r == CLD_ST_IDLE);
    assign op = decode(data_in);

    always_comb begin
        start_long  = 1'b0;
        start_short = 1'b0;
        if (take && !cmd_data_select && !dir_read) begin
            start_long  = (op == CLD_OP_CLEAR) || (op == CLD_OP_HOME);
            start_short = !start_long && (op != CLD_OP_NONE);
        end else if (take && cmd_data_select) begin
            start_short = 1'b1;
        end
    end

    cld_busy_timer #(.LONG_CYC(LONG_CYC)) u_timer (
        .mclk        (mclk),
        .rst_n       (rst_s2_r),
        .start_long  (start_long),
        .start_short (start_short),
        .pending     (pending)
    );

    // clear walks through the buffer one location per cycle
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            state_r   <= CLD_ST_IDLE;
            clr_idx_r <= 6'h00;
        end else begin
            unique case (state_r)
                CLD_ST_IDLE: begin
                    if (start_long && op == CLD_OP_CLEAR) begin
                        state_r   <= CLD_ST_CLEAR;
                        clr_idx_r <= 6'h00;
                    end else if (start_long || start_short) begin
                        state_r <= CLD_ST_WAIT;
                    end
                end
                CLD_ST_CLEAR: begin
                    clr_idx_r <= clr_idx_r + 6'h01;
                    if (clr_idx_r == 6'(`CLD_BUF_DEPTH - 1)) begin
                        state_r <= CLD_ST_WAIT;
                    end
                end
                CLD_ST_WAIT: begin
                    if (!pending) begin
                        state_r <= CLD_ST_IDLE;
                    end
                end
            endcase
        end
    end

    // character buffer storage, no reset
    always_ff @(posedge mclk) begin
        if (state_r == CLD_ST_CLEAR) begin
            buf_mem[clr_idx_r] <= `CLD_SPACE_CODE;
        end else if (take && cmd_data_select && !dir_read && !glyph_sel_r) begin
            buf_mem[buf_index(addr_pointer)] <= data_in;
        end
    end

    always_ff @(posedge mclk) begin
        if (take && cmd_data_select && !dir_read && glyph_sel_r) begin
            glyph_mem[addr_pointer[5:0]] <= data_in;
        end
    end

    // pointer and RAM selection
    always_comb begin
        ptr_nxt = addr_pointer;
        if (take && !cmd_data_select && !dir_read) begin
            unique case (op)
                CLD_OP_CLEAR, CLD_OP_HOME: ptr_nxt = 7'h00;
                CLD_OP_GLYPH_ADDR:         ptr_nxt = {1'b0, data_in[5:0]};
                CLD_OP_BUF_ADDR:           ptr_nxt = data_in[6:0];
                CLD_OP_SHIFT:              ptr_nxt = data_in[3] ? addr_pointer
                                                    : step(addr_pointer, data_in[2]);
                default:                   ptr_nxt = addr_pointer;
            endcase
        end else if (take && cmd_data_select) begin
            ptr_nxt = step(addr_pointer, step_up);
            if (glyph_sel_r) begin
                ptr_nxt[6] = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            addr_pointer <= 7'h00;
            glyph_sel_r  <= 1'b0;
        end else begin
            addr_pointer <= ptr_nxt;
            if (take && !cmd_data_select && !dir_read) begin
                if (op == CLD_OP_GLYPH_ADDR) begin
                    glyph_sel_r <= 1'b1;
                end else if (op == CLD_OP_BUF_ADDR || op == CLD_OP_CLEAR
                             || op == CLD_OP_HOME) begin
                    glyph_sel_r <= 1'b0;
                end
            end
        end
    end

    // mode latches
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            step_up       <= 1'b1;
            auto_scroll   <= 1'b0;
            panel_on      <= 1'b0;
            cursor_on     <= 1'b0;
            blink_on      <= 1'b0;
            bus_width_sel <= 1'b1;
            two_rows      <= 1'b0;
            tall_glyph    <= 1'b0;
        end else if (take && !cmd_data_select && !dir_read) begin
            unique case (op)
                CLD_OP_CLEAR: step_up <= 1'b1;
                CLD_OP_ENTRY: begin
                    step_up     <= data_in[1];
                    auto_scroll <= data_in[0];
                end
                CLD_OP_DISP: begin
                    panel_on  <= data_in[2];
                    cursor_on <= data_in[1];
                    blink_on  <= data_in[0];
                end
                CLD_OP_FUNC: begin
                    bus_width_sel <= data_in[4];
                    two_rows      <= data_in[3];
                    tall_glyph    <= data_in[2];
                end
                default: ;
            endcase
        end
    end

    // display shift offset; panel off only blanks, buffer kept
    always_comb begin
        scroll_step = 1'b0;
        scroll_left = 1'b0;
        if (take && !cmd_data_select && !dir_read && op == CLD_OP_SHIFT && data_in[3]) begin
            scroll_step = 1'b1;
            scroll_left = ~data_in[2];
        end else if (take && cmd_data_select && !dir_read && !glyph_sel_r && auto_scroll) begin
            scroll_step = 1'b1;
            scroll_left = step_up;
        end
    end

    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            scroll_offset <= 6'h00;
        end else if (take && !cmd_data_select && !dir_read
                     && (op == CLD_OP_CLEAR || op == CLD_OP_HOME)) begin
            scroll_offset <= 6'h00;
        end else if (scroll_step) begin
            scroll_offset <= scroll_left ? scroll_offset + 6'h01 : scroll_offset - 6'h01;
        end
    end

    // read path: status read has no execution delay
    always_ff @(posedge mclk or negedge rst_s2_r) begin
        if (!rst_s2_r) begin
            data_out            <= 8'h00;
            data_oe             <= 1'b0;
            internal_op_pending <= 1'b0;
        end else begin
            internal_op_pending <= pending || (state_r != CLD_ST_IDLE) || start_long
                                   || start_short;
            data_oe <= dir_read && strobe;
            if (dir_read && !cmd_data_select) begin
                data_out <= {pending || (state_r != CLD_ST_IDLE), addr_pointer};
            end else if (take && dir_read && cmd_data_select) begin
                data_out <= glyph_sel_r ? glyph_mem[addr_pointer[5:0]]
                                        : buf_mem[buf_index(addr_pointer)];
            end
        end
    end
endmodule

// file: sim/cld_asserts.sv
// concurrent property checker for the character display decoder
`timescale 1ns/1ps
`include "cld_cfg.svh"
module cld_asserts #(parameter int LONG_CYC = 200) (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic       cmd_data_select,
    input wire logic       dir_read,
    input wire logic       strobe,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic       internal_op_pending,
    input wire logic [6:0] addr_pointer,
    input wire logic       step_up,
    input wire logic       auto_scroll,
    input wire logic [5:0] scroll_offset
);
    localparam int SHORT = `CLD_SHORT_CYC;
    logic take;
    logic sd_r;
    logic long_r;
    logic glyph_r;
    int   cnt_r;
    assign take = strobe && !sd_r && !internal_op_pending;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sd_r <= 1'b0;
            long_r <= 1'b0;
            glyph_r <= 1'b0;
            cnt_r <= 0;
        end else begin
            sd_r <= strobe;
            cnt_r <= internal_op_pending ? cnt_r + 1 : 0;
            // every busy access sets the expected length, status reads do not
            if (take && !(dir_read && !cmd_data_select)) begin
                long_r <= !cmd_data_select && data_in[7:2] == 6'h00;
            end
            if (take && !cmd_data_select && !dir_read) begin
                if (data_in[7:6] == 2'b01) glyph_r <= 1'b1;
                if (data_in[7] || (data_in[7:2] == 6'h00 && data_in[1:0] != 2'b00)) begin
                    glyph_r <= 1'b0;
                end
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_ins;
        take && !cmd_data_select && !dir_read;
    endsequence
    sequence s_dat;
        take && cmd_data_select;
    endsequence
    a_glyph_addr: assert property (s_ins ##0 data_in[7:6] == 2'b01
        |=> addr_pointer == {1'b0, $past(data_in[5:0])}) else $error("glyph pointer");
    a_buf_addr: assert property (s_ins ##0 data_in[7]
        |=> addr_pointer == $past(data_in[6:0])) else $error("buffer pointer");
    a_clear_home: assert property (s_ins ##0 data_in == 8'h01
        |=> addr_pointer == 7'h00 && step_up) else $error("clear state");
    a_data_step: assert property (s_dat |=> addr_pointer ==
        (($past(addr_pointer) + ($past(step_up) ? 7'h01 : 7'h7F)) & {!$past(glyph_r), 6'h3F}))
        else $error("pointer step");
    a_auto_scroll: assert property (s_dat ##0 !dir_read && auto_scroll && !glyph_r
        |=> scroll_offset == $past(scroll_offset) + ($past(step_up) ? 6'h01 : 6'h3F))
        else $error("scroll step");
    a_no_scroll: assert property (s_dat ##0 (dir_read || !auto_scroll || glyph_r)
        |=> $stable(scroll_offset)) else $error("stray scroll");
    a_status_read: assert property (take && !cmd_data_select && dir_read
        |=> data_out == {1'b0, $past(addr_pointer)}) else $error("status value");
    a_busy_len: assert property ($fell(internal_op_pending) |-> (long_r ?
        cnt_r >= LONG_CYC && cnt_r <= LONG_CYC + 43 : cnt_r >= SHORT && cnt_r <= SHORT + 3))
        else $error("busy length");
endmodule
bind cld_decoder cld_asserts #(.LONG_CYC(LONG_CYC)) u_chk (.mclk, .rst_n, .cmd_data_select,
    .dir_read, .strobe, .data_in, .data_out, .internal_op_pending, .addr_pointer, .step_up,
    .auto_scroll, .scroll_offset);

// file: sim/cld_host.sv
// host bus model issuing instructions and data transfers
`timescale 1ns/1ps
module cld_host (
    input  wire logic       mclk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic       internal_op_pending,
    output logic            cmd_data_select,
    output logic            dir_read,
    output logic            strobe,
    output logic      [7:0] data_in
);
    initial begin
        cmd_data_select = 1'b0;
        dir_read = 1'b0;
        strobe = 1'b0;
        data_in = 8'h00;
    end
    // strobe low and high phases kept above the minimum pulse width
    task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q, output logic oe, output int n);
        repeat (12) @(posedge mclk);
        cmd_data_select <= rs;
        dir_read <= rw;
        data_in <= d;
        strobe <= 1'b1;
        repeat (13) @(posedge mclk);
        #1 q = data_out;
        oe = data_oe;
        @(posedge mclk);
        strobe <= 1'b0;
        data_in <= ~d;
        #1 n = 12;
        while (internal_op_pending === 1'b1 && n < 9000) begin
            @(posedge mclk);
            #1 n = n + 1;
        end
    endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the character display decoder
`timescale 1ns/1ps
`include "cld_cfg.svh"
module tb_top;
    import cld_pkg::*;
    localparam int LONG = 200;
    localparam int SHORT = `CLD_SHORT_CYC;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    logic       cmd_data_select, dir_read, strobe, internal_op_pending;
    logic [7:0] data_in, data_out, q;
    logic       data_oe, oe;
    logic [6:0] addr_pointer;
    logic [5:0] scroll_offset;
    logic       panel_on, cursor_on, blink_on, bus_width_sel, two_rows, tall_glyph;
    logic       step_up, auto_scroll;
    int         n_errors = 0;
    int         checks = 0;
    int         n;
    always #10 mclk = ~mclk;
    cld_decoder #(.LONG_CYC(LONG)) u_dut (.mclk, .rst_n, .cmd_data_select, .dir_read, .strobe,
        .data_in, .data_out, .data_oe, .internal_op_pending, .addr_pointer, .panel_on,
        .cursor_on, .blink_on, .bus_width_sel, .two_rows, .tall_glyph, .step_up,
        .auto_scroll, .scroll_offset);
    cld_host u_host (.mclk, .data_out, .data_oe, .internal_op_pending, .cmd_data_select, .dir_read,
        .strobe, .data_in);
    task automatic final_report();
        if (n_errors == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask
    // op code: bit 9 data select, bit 8 read, low byte bus value
    task automatic run(input logic [9:0] ops [$]);
        logic lng;
        foreach (ops[i]) begin
            u_host.xfer(ops[i][9], ops[i][8], ops[i][7:0], q, oe, n);
            if (n >= 9000) begin
                n_errors++;
                $display("BAD busy_wait exp low got high");
                final_report();
            end
            chk("oe", {7'h00, ops[i][8]}, {7'h00, oe});
            lng = ops[i][9:2] == 8'h00;
            // status reads and the empty instruction start no busy time
            if (ops[i][9:8] == 2'b01 || ops[i] == 10'h000) chk("idle", 8'h0C, n[7:0]);
            else chk("busy", 8'h01, {7'h00, lng ?
                n >= LONG && n <= LONG + 43 : n >= SHORT && n <= SHORT + 3});
        end
    endtask
    task automatic t_modes();
        logic [7:0] fn [2] = '{8'h27, 8'h3B};
        logic [7:0] dc [2] = '{8'h0A, 8'h0F};
        for (int i = 0; i < 2; i++) begin
            run('{{2'b00, fn[i]}, {2'b00, dc[i]}});
            chk("func", {5'h00, fn[i][4:2]}, {5'h00, bus_width_sel, two_rows, tall_glyph});
            chk("disp", {5'h00, dc[i][2:0]}, {5'h00, panel_on, cursor_on, blink_on});
        end
    endtask
    task automatic t_buf();
        run('{10'h006, 10'h0C0, 10'h241, 10'h242});
        chk("ptr_up", 8'h42, {1'b0, addr_pointer});
        run('{10'h004, 10'h093, 10'h255});
        chk("ptr_dn", 8'h12, {1'b0, addr_pointer});
        run('{10'h093, 10'h300});
        chk("row1_end", 8'h55, q);
        run('{10'h0C1, 10'h300});
        chk("row2", 8'h42, q);
        run('{10'h000, 10'h100});
        chk("status", 8'h40, q);
    endtask
    task automatic t_glyph();
        run('{10'h007, 10'h045, 10'h21F});
        chk("glyph_ptr", 8'h06, {1'b0, addr_pointer});
        chk("no_scroll", 8'h00, {2'b00, scroll_offset});
        run('{10'h045, 10'h300});
        chk("glyph_rd", 8'h1F, q);
    endtask
    task automatic t_scroll();
        run('{10'h080, 10'h261});
        chk("scroll_l", 8'h01, {2'b00, scroll_offset});
        run('{10'h005, 10'h262, 10'h018, 10'h014});
        chk("shift_ofs", 8'h01, {2'b00, scroll_offset});
        chk("shift_ptr", 8'h01, {1'b0, addr_pointer});
        run('{10'h006, 10'h008, 10'h0C0, 10'h300});
        chk("panel_off", 8'h41, q);
        run('{10'h002});
        chk("home", 8'h00, {1'b0, addr_pointer} | {2'b00, scroll_offset});
        run('{10'h300});
        chk("kept", 8'h61, q);
    endtask
    task automatic t_clear();
        run('{10'h004, 10'h001});
        chk("clear", 8'h80, {step_up, addr_pointer});
        run('{10'h0C1, 10'h300});
        chk("space", 8'h20, q);
    endtask
    initial begin
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("rst", 8'h06, {addr_pointer[4:0], step_up, bus_width_sel, panel_on});
        t_modes();
        t_buf();
        t_glyph();
        t_scroll();
        t_clear();
        final_report();
    end
endmodule
